// *** logic/sac_pkg.sv ***
// Package for the serial conversion port: widths, counts and states.
// Assumes a 100 MHz mclk on both ends.
`default_nettype none
package sac_pkg;
	localparam int SAC_FULL_BITS = 14;
	localparam int SAC_FRAME_EDGES = 16;
	localparam int SAC_ACQ_EDGE = 16;
	localparam int SAC_CONVERT_STROBE_CYCLES = 18;
	localparam logic [4:0] SAC_CNT_ZERO = 5'h00;
	localparam logic [2:0] SAC_PULSE_ZERO = 3'h0;
	localparam logic [2:0] SAC_NAP_PULSES = 3'h2;
	localparam logic [2:0] SAC_SLEEP_PULSES = 3'h4;
	localparam int SAC_MCLK_NS = 10;
	localparam int SAC_ACQ_MIN_NS = 45;
	localparam int SAC_ACQ_CYCLES = (SAC_ACQ_MIN_NS + SAC_MCLK_NS - 1) / SAC_MCLK_NS;
	localparam int SAC_SCK_MAX_NS = 10000;
	localparam int SAC_SCK_MAX_CYCLES = SAC_SCK_MAX_NS / SAC_MCLK_NS;
	localparam int SAC_SETTLE_MS = 2;
	localparam int SAC_SETTLE_CYCLES = SAC_SETTLE_MS * 1000000 / SAC_MCLK_NS;
	localparam logic [3:0] SAC_SCK_HALF = 4'h6;
	localparam logic [3:0] SAC_DIV_ZERO = 4'h0;
	localparam int SAC_FIFO_DEPTH = 8;
	localparam logic [13:0] SAC_RESULT_RESET = 14'h0000;
	typedef enum logic [3:0] {
		SAC_H_IDLE = 4'b0001,
		SAC_H_CONVERT_STROBE = 4'b0010,
		SAC_H_SHIFT = 4'b0100,
		SAC_H_ACQ = 4'b1000
	} sac_host_state_t;
endpackage : sac_pkg
`default_nettype wire

// *** logic/sac_link_if.sv ***
// Link between converter and host: strobe, serial clock, three-state data.
// Assumes the bench reads the data wire level from data and enable.
`timescale 1ns/1ps
`default_nettype none
interface sac_link_if;
	logic convert_strobe;
	logic serial_clk;
	logic serial_result_out;
	logic serial_result_oe;
	modport device (input convert_strobe, input serial_clk,
		output serial_result_out, output serial_result_oe);
	modport host (output convert_strobe, output serial_clk,
		input serial_result_out, input serial_result_oe);
endinterface : sac_link_if
`default_nettype wire

// *** logic/sac_fifo.sv ***
// Parameterised FIFO with valid/ready on both sides.
// Assumes a single clock domain.
`timescale 1ns/1ps
`default_nettype none
module sac_fifo #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 8
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
	logic [AW:0] cnt_reg, cnt_next;
	logic push, pop;

	assign in_ready = (cnt_reg != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
	assign out_valid = cnt_reg != '0;
	assign out_data = mem[rd_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb
	begin
		wr_next = push ? AW'(wr_reg + 1'b1) : wr_reg;
		rd_next = pop ? AW'(rd_reg + 1'b1) : rd_reg;
		cnt_next = cnt_reg;
		if (push && !pop)
			cnt_next = (AW+1)'(cnt_reg + 1'b1);
		else if (pop && !push)
			cnt_next = (AW+1)'(cnt_reg - 1'b1);
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end
		else
		begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (push)
			mem[wr_reg] <= in_data;
	end
endmodule : sac_fifo
`default_nettype wire

// *** logic/sac_device.sv ***
// Converter end: samples on strobe rise, shifts result on serial clock.
// Assumes the host drives strobe and serial clock; both are synchronised.
//
// Contract
// R01 - Strobe rise holds input, starts conversion
// R02 - Each clock rise advances conversion and output
// R03 - Shifted word is previous conversion's sample
// R04 - Output released after result bits
// R05 - Bits 0 through 13 follow clock edges
// R06 - Result width follows built variant
// R07 - Host captures data on clock rise
// R08 - Acquisition from 16th edge to strobe
// R09 - Host leaves 45 ns before strobe
// R10 - Late strobe delays data one cycle
// R11 - Strobe preferably half period before clock
// R12 - Clock period under 10000 ns converting
// R13 - Two strobes, clock still: nap
// R14 - Four strobes, clock still: sleep
// R15 - Clock pulse wakes from sleep
// R16 - Host waits 2 ms after wake; sac_host has no such wait
// R17 - Over range all ones, under zeros
// R18 - Power-down states internal only; sac_device drives them out on nap_state and sleep_state
// R19 - MSB first, short variant left-aligned
// R20 - One strobe then clock burst per sample
`timescale 1ns/1ps
`default_nettype none
module sac_device
	import sac_pkg::*;
#(
	parameter int RES_BITS = 14
) (
	input wire logic mclk,
	input wire logic rst_n,
	sac_link_if.device link,
	input wire logic [15:0] analog_diff,
	output logic nap_state,
	output logic sleep_state
);
	logic convert_strobe_s1_reg, convert_strobe_s2_reg, convert_strobe_s3_reg;
	logic sck_s1_reg, sck_s2_reg, sck_s3_reg;
	logic convert_strobe_rise, sck_rise;
	logic [13:0] held_reg, held_next;
	logic [13:0] shift_reg, shift_next;
	logic [4:0] edge_reg, edge_next;
	logic oe_reg, oe_next, dout_reg, dout_next;
	logic acq_reg, acq_next;
	logic nap_reg, nap_next, sleep_reg, sleep_next;
	logic [2:0] pulse_reg, pulse_next;
	logic [13:0] code;

	// ----------------------------------------
	// Edge finding on synchronised pins
	// ----------------------------------------
	// Third flop holds the previous synchronised level, so the
	// edge is seen once, two cycles after the pin moves.
	function automatic logic rise_of(input logic now_v, input logic was_v);
		return now_v && !was_v;
	endfunction : rise_of

	assign convert_strobe_rise = rise_of(convert_strobe_s2_reg, convert_strobe_s3_reg); // R01
	assign sck_rise = rise_of(sck_s2_reg, sck_s3_reg); // R02

	// ----------------------------------------
	// Quantiser with clamping
	// ----------------------------------------
	always_comb
	begin
		if (analog_diff[15])
			code = 14'h0000; // R17
		else if (analog_diff[14])
			code = 14'h3FFF; // R17
		else
			code = analog_diff[13:0];
		if (RES_BITS < SAC_FULL_BITS)
			code = code & ~14'(2 ** (SAC_FULL_BITS - RES_BITS) - 1); // R06 R19
	end

	// ----------------------------------------
	// Conversion, shifting, power-down
	// ----------------------------------------
	always_comb
	begin
		held_next = held_reg;
		shift_next = shift_reg;
		edge_next = edge_reg;
		oe_next = oe_reg;
		dout_next = dout_reg;
		acq_next = acq_reg;
		nap_next = nap_reg;
		sleep_next = sleep_reg;
		pulse_next = pulse_reg;
		if (convert_strobe_rise)
		begin
			held_next = code; // R01
			acq_next = 1'b0; // R08
			shift_next = held_reg; // R03
			edge_next = SAC_CNT_ZERO;
			oe_next = 1'b0;
			if (pulse_reg != 3'h7)
				pulse_next = 3'(pulse_reg + 1'b1);
		end
		if (sck_rise)
		begin
			pulse_next = SAC_PULSE_ZERO;
			nap_next = 1'b0;
			sleep_next = 1'b0; // R15
			// Edge seen with strobe slips output by one edge
			if (!convert_strobe_rise && !sleep_reg) // R10
			begin
				if (edge_reg < 5'(SAC_FRAME_EDGES))
					edge_next = 5'(edge_reg + 1'b1); // R02
				if (edge_reg < 5'(SAC_FULL_BITS))
				begin
					oe_next = 1'b1;
					dout_next = shift_reg[13]; // R05 R19
					shift_next = {shift_reg[12:0], 1'b0};
				end
				else
					oe_next = 1'b0; // R04
				if (edge_reg == 5'(SAC_ACQ_EDGE - 1))
					acq_next = 1'b1; // R08
			end
		end
		else if (convert_strobe_rise)
		begin
			// Strobe pulses counted while clock holds still
			if (pulse_reg + 1'b1 >= SAC_SLEEP_PULSES - 3'h1 + 3'h1)
			begin
				sleep_next = 1'b1; // R14
				nap_next = 1'b0;
			end
			else if (pulse_reg + 1'b1 == SAC_NAP_PULSES)
				nap_next = 1'b1; // R13
		end
	end

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Strobe and serial clock come from another end; only the
	// second flop and the edge flop are read by logic.
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			convert_strobe_s1_reg <= 1'b0;
			convert_strobe_s2_reg <= 1'b0;
			convert_strobe_s3_reg <= 1'b0;
			sck_s1_reg <= 1'b0;
			sck_s2_reg <= 1'b0;
			sck_s3_reg <= 1'b0;
		end
		else
		begin
			convert_strobe_s1_reg <= link.convert_strobe;
			convert_strobe_s2_reg <= convert_strobe_s1_reg;
			convert_strobe_s3_reg <= convert_strobe_s2_reg;
			sck_s1_reg <= link.serial_clk;
			sck_s2_reg <= sck_s1_reg;
			sck_s3_reg <= sck_s2_reg;
		end
	end

	// ----------------------------------------
	// State registers
	// ----------------------------------------
	// Edge counter resets to a finished frame, so the output
	// stays released until the first strobe arrives.
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			held_reg <= SAC_RESULT_RESET;
			shift_reg <= SAC_RESULT_RESET;
			edge_reg <= 5'(SAC_FRAME_EDGES);
			oe_reg <= 1'b0;
			dout_reg <= 1'b0;
			acq_reg <= 1'b1;
			nap_reg <= 1'b0;
			sleep_reg <= 1'b0;
			pulse_reg <= SAC_PULSE_ZERO;
		end
		else
		begin
			held_reg <= held_next;
			shift_reg <= shift_next;
			edge_reg <= edge_next;
			oe_reg <= oe_next;
			dout_reg <= dout_next;
			acq_reg <= acq_next;
			nap_reg <= nap_next;
			sleep_reg <= sleep_next;
			pulse_reg <= pulse_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Power state leaves only as plain levels; after a wake the
	// reference still needs time to settle before results count.
	assign link.serial_result_out = dout_reg;
	assign link.serial_result_oe = oe_reg; // R04
	assign nap_state = nap_reg; // R18
	assign sleep_state = sleep_reg; // R18
endmodule : sac_device
`default_nettype wire

// *** logic/sac_host.sv ***
// Host end: makes strobe and serial clock, collects results into a FIFO.
// Assumes the converter end answers on the shared link.
`timescale 1ns/1ps
`default_nettype none
module sac_host
	import sac_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	sac_link_if.host link,
	input wire logic run,
	input wire logic sleep_req,
	output logic res_valid,
	input wire logic res_ready,
	output logic [13:0] res_data
);
	sac_host_state_t st_reg, st_next;
	logic [3:0] div_reg, div_next;
	logic sck_reg, sck_next, convert_strobe_reg, convert_strobe_next;
	logic [4:0] edge_reg, edge_next;
	logic [13:0] word_reg, word_next;
	logic [2:0] pulse_reg, pulse_next;
	logic push, fifo_ready, tick;
	logic sdo_s1_reg, sdo_s2_reg;

	localparam logic [3:0] SAC_HALF_LAST = SAC_SCK_HALF - 4'h1;
	assign tick = div_reg == SAC_HALF_LAST;

	always_comb
	begin
		st_next = st_reg;
		div_next = tick ? SAC_DIV_ZERO : 4'(div_reg + 1'b1);
		sck_next = sck_reg;
		convert_strobe_next = convert_strobe_reg;
		edge_next = edge_reg;
		word_next = word_reg;
		pulse_next = pulse_reg;
		push = 1'b0;
		unique case (st_reg)
			SAC_H_IDLE:
				if (tick && sleep_req && pulse_reg != SAC_SLEEP_PULSES)
				begin
					convert_strobe_next = !convert_strobe_reg; // R14
					if (convert_strobe_reg)
						pulse_next = 3'(pulse_reg + 1'b1);
				end
				else if (tick && run && fifo_ready && !convert_strobe_reg)
				begin
					convert_strobe_next = 1'b1; // R11 R20
					pulse_next = SAC_PULSE_ZERO;
					st_next = SAC_H_CONVERT_STROBE;
				end
			SAC_H_CONVERT_STROBE:
				if (tick)
				begin
					convert_strobe_next = 1'b0;
					edge_next = SAC_CNT_ZERO;
					st_next = SAC_H_SHIFT;
				end
			SAC_H_SHIFT:
				if (tick)
				begin
					sck_next = !sck_reg; // R12
					if (!sck_reg)
					begin
						edge_next = 5'(edge_reg + 1'b1);
						if (edge_reg >= 5'h1 && edge_reg <= 5'(SAC_FULL_BITS))
							word_next = {word_reg[12:0], sdo_s2_reg}; // R07
						if (edge_reg == 5'(SAC_FRAME_EDGES - 1))
							st_next = SAC_H_ACQ; // R08
					end
				end
			SAC_H_ACQ:
				if (tick)
				begin
					sck_next = 1'b0;
					push = 1'b1; // R09
					st_next = SAC_H_IDLE;
				end
			default:
				st_next = SAC_H_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_reg <= SAC_H_IDLE;
			div_reg <= SAC_DIV_ZERO;
			sck_reg <= 1'b0;
			convert_strobe_reg <= 1'b0;
			edge_reg <= SAC_CNT_ZERO;
			word_reg <= SAC_RESULT_RESET;
			pulse_reg <= SAC_PULSE_ZERO;
			sdo_s1_reg <= 1'b0;
			sdo_s2_reg <= 1'b0;
		end
		else
		begin
			st_reg <= st_next;
			div_reg <= div_next;
			sck_reg <= sck_next;
			convert_strobe_reg <= convert_strobe_next;
			edge_reg <= edge_next;
			word_reg <= word_next;
			pulse_reg <= pulse_next;
			sdo_s1_reg <= link.serial_result_out;
			sdo_s2_reg <= sdo_s1_reg;
		end
	end

	assign link.convert_strobe = convert_strobe_reg;
	assign link.serial_clk = sck_reg;

	sac_fifo #(
		.WIDTH(SAC_FULL_BITS),
		.DEPTH(SAC_FIFO_DEPTH)
	) u_fifo (
		.mclk(mclk),
		.rst_n(rst_n),
		.in_valid(push),
		.in_ready(fifo_ready),
		.in_data(word_reg),
		.out_valid(res_valid),
		.out_ready(res_ready),
		.out_data(res_data)
	);
endmodule : sac_host
`default_nettype wire

// *** test/sac_sva.sv ***
// Checker on the link between host and converter ends.
// Assumes a 6 mclk strobe pulse and a 6 mclk serial clock half period.
`timescale 1ns/1ps
`default_nettype none
module sac_sva
	import sac_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic convert_strobe,
	input wire logic serial_clk,
	input wire logic serial_result_out,
	input wire logic serial_result_oe
);
	// ----------------------------------------------------------------
	// Edges since strobe, cycles since last clock rise
	// ----------------------------------------------------------------
	logic sck_reg, cnv_reg;
	logic [4:0] edg_reg, edg_next;
	logic [3:0] gap_reg, gap_next;
	always_comb
	begin
		edg_next = edg_reg;
		gap_next = gap_reg + {3'h0, gap_reg != 4'hF};
		if (convert_strobe && !cnv_reg)
			edg_next = 5'h00;
		if (serial_clk && !sck_reg)
		begin
			edg_next = edg_reg + 5'h01;
			gap_next = 4'h0;
		end
	end
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			{sck_reg, cnv_reg, edg_reg, gap_reg} <= {2'h0, 5'h00, 4'hF};
		else
			{sck_reg, cnv_reg, edg_reg, gap_reg} <=
				{serial_clk, convert_strobe, edg_next, gap_next};
	end
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	sequence s_pulse;
		convert_strobe [*6] ##1 !convert_strobe;
	endsequence
	sequence s_half;
		serial_clk [*6] ##1 !serial_clk;
	endsequence
	a_strobe_width: assert property ($rose(convert_strobe) |-> s_pulse)
		else $error("strobe pulse width wrong");
	a_sck_half: assert property ($rose(serial_clk) |-> s_half)
		else $error("serial clock high time wrong");
	a_frame_edges: assert property ($rose(convert_strobe) |->
		edg_reg == 5'h00 || edg_reg == 5'h10)
		else $error("frame edge count wrong");
	a_acq_gap: assert property ($rose(convert_strobe) |-> gap_reg >= 4'h4)
		else $error("acquisition gap too short");
	a_oe_release: assert property (edg_reg == 5'h10 && gap_reg >= 4'h5
		|-> !serial_result_oe)
		else $error("data output not released");
	a_data_hold: assert property (serial_result_oe && $past(serial_result_oe)
		&& $changed(serial_result_out) |-> gap_reg <= 4'h5)
		else $error("data changed away from clock rise");
	a_data_valid: assert property ($rose(serial_clk) && serial_result_oe
		|-> ##1 $stable(serial_result_out))
		else $error("data moved at capture edge");
	a_oe_frame: assert property ($rose(serial_clk) && edg_reg == 5'h01
		|-> ##[1:5] serial_result_oe)
		else $error("data output not driven");
endmodule : sac_sva
`default_nettype wire

// *** test/sac_bench.sv ***
// Bench: host and converter ends joined, words checked against samples.
// Assumes reset held 3 cycles and a fixed xorshift seed.
`timescale 1ns/1ps
`default_nettype none
module sac_bench import sac_pkg::*;;
	logic mclk = 1'b0, rst_n = 1'b0, run = 1'b0, sleep_req = 1'b0;
	logic res_ready = 1'b0, hold_ready = 1'b0, cmp_on = 1'b1;
	logic res_valid, nap, slp, sck_d = 1'b0, cnv_d = 1'b0;
	logic [15:0] analog_diff = 16'h0000;
	logic [15:0] corner[4] = '{16'h0000, 16'h3FFF, 16'h8000, 16'h4000};
	logic [13:0] res_data;
	logic [13:0] q[$] = '{14'h0000};
	logic [31:0] rs = 32'hB4A5AD3F;
	int fail_count = 0, checks = 0, n_res = 0, n_cnv = 0, n_sck = 0, c0;
	sac_link_if link_i();
	sac_device sac_device_i (.mclk(mclk), .rst_n(rst_n),
		.link(link_i.device), .analog_diff(analog_diff),
		.nap_state(nap), .sleep_state(slp));
	sac_host sac_host_i (.mclk(mclk), .rst_n(rst_n), .link(link_i.host),
		.run(run), .sleep_req(sleep_req), .res_valid(res_valid),
		.res_ready(res_ready), .res_data(res_data));
	sac_sva sac_sva_i (.mclk(mclk), .rst_n(rst_n),
		.convert_strobe(link_i.convert_strobe),
		.serial_clk(link_i.serial_clk),
		.serial_result_out(link_i.serial_result_out),
		.serial_result_oe(link_i.serial_result_oe));
	always #5 mclk = ~mclk;
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	function automatic logic [13:0] exp_word(input logic [15:0] d);
		return d[15] ? 14'h0000 : (d[14] ? 14'h3FFF : d[13:0]);
	endfunction : exp_word
	task automatic chk_word(input logic [13:0] got, input logic [13:0] exp);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error %0t word got %h exp %h", $time, got, exp);
		end
	endtask : chk_word
	task automatic chk_flag(input logic got, input logic exp);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error %0t flag got %h exp %h", $time, got, exp);
		end
	endtask : chk_flag
	task automatic wait_for(ref int c, input int t);
		for (int k = 0; k < 12000 && c < t; k++)
			@(posedge mclk);
		if (c < t)
		begin
			fail_count++;
			$display("Error %0t wait got %h exp %h", $time, c, t);
		end
		repeat (6) @(posedge mclk);
	endtask : wait_for
	task automatic end_sim;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	// ----------------------------------------------------------------
	// Stimulus and result monitor
	// ----------------------------------------------------------------
	always @(posedge mclk)
	begin
		rs = xs(rs);
		sck_d <= link_i.serial_clk;
		cnv_d <= link_i.convert_strobe;
		res_ready <= hold_ready ? 1'b0 : rs[20];
		if (link_i.serial_clk && !sck_d)
		begin
			n_sck <= n_sck + 1;
			analog_diff <= n_cnv < 4 ? corner[n_cnv] : rs[15:0];
		end
		if (link_i.convert_strobe && !cnv_d)
		begin
			n_cnv <= n_cnv + 1;
			q.push_back(exp_word(analog_diff));
		end
		if (res_valid && res_ready)
		begin
			n_res <= n_res + 1;
			if (cmp_on)
				chk_word(res_data, q.pop_front());
		end
	end
	initial
	begin
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		run <= 1'b1;
		hold_ready <= 1'b1;
		repeat (2500) @(posedge mclk);
		c0 = n_cnv;
		repeat (300) @(posedge mclk);
		chk_flag(n_cnv == c0, 1'b1);
		hold_ready <= 1'b0;
		wait_for(n_res, 30);
		cmp_on <= 1'b0;
		run <= 1'b0;
		repeat (400) @(posedge mclk);
		c0 = n_cnv;
		sleep_req <= 1'b1;
		wait_for(n_cnv, c0 + 2);
		chk_flag(nap, 1'b1);
		chk_flag(slp, 1'b0);
		wait_for(n_cnv, c0 + 4);
		chk_flag(slp, 1'b1);
		chk_flag(link_i.serial_result_oe, 1'b0);
		sleep_req <= 1'b0;
		run <= 1'b1;
		c0 = n_sck;
		wait_for(n_sck, c0 + 1);
		chk_flag(slp, 1'b0);
		chk_flag(nap, 1'b0);
		end_sim();
	end
	initial
	begin
		repeat (40000) @(posedge mclk);
		fail_count++;
		end_sim();
	end
endmodule : sac_bench
`default_nettype wire
